//--- common/dbm_pkg.sv
// Purpose: shared constants for the data breakpoint match and execution control block
// Assumes: debug control register numbers are 5 bits wide
// Notes: operand size encoding on the bus observation port is local to this block
package dbm_pkg;

  // ***************************************
  // debug control register numbers
  // ***************************************
  localparam logic [4:0] REG_PATTERN_A = 5'h0E;
  localparam logic [4:0] REG_MASK_A = 5'h0F;
  localparam logic [4:0] REG_PATTERN_B = 5'h1E;
  localparam logic [4:0] REG_MASK_B = 5'h1F;

  // ***************************************
  // operand size encoding
  // ***************************************
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ***************************************
  // timing
  // ***************************************
  // extra cycles added after every instruction in serial execution
  localparam int SERIAL_EXTRA_CYC = 5;
  localparam logic [2:0] GAP_LOAD = 3'(SERIAL_EXTRA_CYC - 1);

  // read data shown for registers that cannot be read back
  localparam logic [31:0] RD_NONE = 32'h0000_0000;

  typedef enum logic [1:0] {ST_RUN, ST_BUSY, ST_GAP, ST_HALT} dbm_state_t;

endpackage

//--- src/dbm_data_match.sv
// Contract
// - serial bit set runs one instruction at once
// - serial mode disables folding, adds five cycles
// - pc breakpoint reported before its instruction executes
// - serial mode reports address/data triggers precisely
// - step bit halts after every instruction
// - resume while halted runs exactly one instruction
// - two 32-bit patterns compared with bus data
// - mask bit one ignores that bit position
// - register numbers 0E, 1E patterns, 0F, 1F masks
// - patterns read/write via port; masks write-only
// - byte operand lane chosen by address bits
// - words by address bit one, longword all lanes
//
// Purpose: data breakpoint comparators plus serial and single-step execution control
// Assumes: all inputs synchronous to clk; core gives one instrDone per granted instruction
// Notes: patterns and masks have no reset value; load them before enabling a match
`timescale 1ns/1ps
module dbm_data_match
  import dbm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // supervisor debug write instruction
  input wire logic instrWrEn,
  input wire logic [4:0] instrRegNum,
  input wire logic [31:0] instrWrData,
  // background debug port register commands
  input wire logic portWrEn,
  input wire logic portRdEn,
  input wire logic [4:0] portRegNum,
  input wire logic [31:0] portWrData,
  output logic portRdAck_r,
  output logic [31:0] portRdData_r,
  // local bus observation
  input wire logic busValid,
  input wire logic [1:0] busAddr,
  input wire logic [1:0] busSize,
  input wire logic [31:0] busData,
  // size conditions enabled by the trigger definition logic
  input wire logic trigEnLong,
  input wire logic trigEnWordUpper,
  input wire logic trigEnWordLower,
  input wire logic [3:0] trigEnByte,
  output logic [1:0] dataMatch_r,
  // execution control bits from the config/status register
  input wire logic serialExecSelect,
  input wire logic stepHaltEnable,
  // core handshake
  input wire logic issueReq,
  input wire logic instrDone,
  input wire logic pcBpHit,
  input wire logic resumeCmd,
  output logic issueGrant_r,
  output logic foldDisable_r,
  output logic pcTrigReport_r,
  output logic halted_r
);

  // ***************************************
  // register file
  // ***************************************
  logic [31:0] pattern_r [2];
  logic [31:0] pattern_nxt [2];
  logic [31:0] mask_r [2];
  logic [31:0] mask_nxt [2];
  logic portRdAck_nxt;
  logic [31:0] portRdData_nxt;
  logic wrEn;
  logic [4:0] wrNum;
  logic [31:0] wrData;

  always_comb begin
    // the port wins over the instruction if both write in one cycle
    wrEn = portWrEn | instrWrEn;
    wrNum = portWrEn ? portRegNum : instrRegNum;
    wrData = portWrEn ? portWrData : instrWrData;
    pattern_nxt = pattern_r;
    mask_nxt = mask_r;
    if (wrEn) begin
      case (wrNum)
        REG_PATTERN_A: pattern_nxt[0] = wrData;
        REG_PATTERN_B: pattern_nxt[1] = wrData;
        REG_MASK_A: mask_nxt[0] = wrData;
        REG_MASK_B: mask_nxt[1] = wrData;
        default: begin
        end
      endcase
    end
    portRdAck_nxt = portRdEn;
    case (portRegNum)
      REG_PATTERN_A: portRdData_nxt = pattern_r[0];
      REG_PATTERN_B: portRdData_nxt = pattern_r[1];
      default: portRdData_nxt = RD_NONE;
    endcase
    if (!portRdEn) begin
      portRdData_nxt = portRdData_r;
    end
  end

  // patterns and masks are left uninitialized by reset
  always_ff @(posedge clk) begin
    pattern_r <= pattern_nxt;
    mask_r <= mask_nxt;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      portRdAck_r <= 1'b0;
      portRdData_r <= RD_NONE;
    end else begin
      portRdAck_r <= portRdAck_nxt;
      portRdData_r <= portRdData_nxt;
    end
  end

  // ***************************************
  // operand lanes and comparators
  // ***************************************
  logic [31:0] laneBits;
  logic sizeOk;
  logic [1:0] dataMatch_nxt;

  always_comb begin
    laneBits = 32'h0000_0000;
    sizeOk = 1'b0;
    case (busSize)
      SIZE_BYTE: begin
        case (busAddr)
          2'h0: laneBits = 32'hFF00_0000;
          2'h1: laneBits = 32'h00FF_0000;
          2'h2: laneBits = 32'h0000_FF00;
          default: laneBits = 32'h0000_00FF;
        endcase
        sizeOk = trigEnByte[2'h3 - busAddr];
      end
      SIZE_WORD: begin
        laneBits = busAddr[1] ? 32'h0000_FFFF : 32'hFFFF_0000;
        sizeOk = busAddr[1] ? trigEnWordLower : trigEnWordUpper;
      end
      SIZE_LONG: begin
        laneBits = 32'hFFFF_FFFF;
        sizeOk = trigEnLong;
      end
      default: begin
      end
    endcase
  end

  for (genvar i = 0; i < 2; i++) begin : g_cmp
    // mask bit one drops the position from the compare
    assign dataMatch_nxt[i] = busValid && sizeOk &&
      (((busData ^ pattern_r[i]) & ~mask_r[i] & laneBits) == 32'h0000_0000);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dataMatch_r <= 2'h0;
    end else begin
      dataMatch_r <= dataMatch_nxt;
    end
  end

  // ***************************************
  // execution control
  // ***************************************
  dbm_state_t state_r;
  dbm_state_t state_nxt;
  logic [2:0] gapCnt_r;
  logic [2:0] gapCnt_nxt;
  logic issueGrant_nxt;
  logic pcTrigReport_nxt;

  always_comb begin
    state_nxt = state_r;
    gapCnt_nxt = gapCnt_r;
    issueGrant_nxt = 1'b0;
    // a pc hit holds back the issue so it is seen before the instruction runs
    pcTrigReport_nxt = pcBpHit && issueReq;
    case (state_r)
      ST_RUN: begin
        if (issueReq && !pcBpHit) begin
          issueGrant_nxt = 1'b1;
          if (serialExecSelect || stepHaltEnable) begin
            state_nxt = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        if (instrDone) begin
          if (serialExecSelect) begin
            state_nxt = ST_GAP;
            gapCnt_nxt = GAP_LOAD;
          end else if (stepHaltEnable) begin
            state_nxt = ST_HALT;
          end else begin
            state_nxt = ST_RUN;
          end
        end
      end
      ST_GAP: begin
        if (gapCnt_r == 3'h0) begin
          state_nxt = stepHaltEnable ? ST_HALT : ST_RUN;
        end else begin
          gapCnt_nxt = gapCnt_r - 3'h1;
        end
      end
      ST_HALT: begin
        // register commands stay serviced while halted
        if (resumeCmd) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_RUN;
      gapCnt_r <= 3'h0;
      issueGrant_r <= 1'b0;
      pcTrigReport_r <= 1'b0;
      foldDisable_r <= 1'b0;
      halted_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      gapCnt_r <= gapCnt_nxt;
      issueGrant_r <= issueGrant_nxt;
      pcTrigReport_r <= pcTrigReport_nxt;
      foldDisable_r <= serialExecSelect;
      halted_r <= (state_nxt == ST_HALT);
    end
  end

  // ***************************************
  // checks
  // ***************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_serial_single: assert property (
    (state_r == ST_BUSY && $past(state_r) == ST_BUSY) |-> !issueGrant_r)
    else $error("grant while serial instruction in flight");

  chk_serial_gap: assert property (
    (state_r == ST_BUSY && instrDone && serialExecSelect) |=> !issueGrant_r [*5])
    else $error("serial gap shorter than five cycles");

  chk_fold_off: assert property (
    (issueGrant_r && $past(serialExecSelect, 2) && $past(serialExecSelect)) |-> foldDisable_r)
    else $error("folding left on in serial mode");

  chk_pc_first: assert property (
    (pcBpHit && issueReq) |=> (pcTrigReport_r && !issueGrant_r))
    else $error("instruction granted before pc trigger report");

  chk_trig_precise: assert property (
    (serialExecSelect && state_r == ST_BUSY && instrDone) |=> ##1 !issueGrant_r)
    else $error("next instruction began before trigger report");

  chk_step_halt: assert property (
    (state_r == ST_BUSY && instrDone && stepHaltEnable && !serialExecSelect) |=> halted_r)
    else $error("no halt after stepped instruction");

  chk_resume_one: assert property (
    (halted_r && resumeCmd && stepHaltEnable && !serialExecSelect) |=> !halted_r ##0
    (issueReq && !pcBpHit && stepHaltEnable) |=> (issueGrant_r ##1 !issueGrant_r))
    else $error("resume did not run exactly one instruction");

  chk_mask_ignore: assert property (
    (busValid && sizeOk && mask_r[1] == 32'hFFFF_FFFF && !wrEn) |=> dataMatch_r[1])
    else $error("fully masked compare did not match");

  chk_long_match: assert property (
    (busValid && busSize == SIZE_LONG && trigEnLong && busData == pattern_r[0]) |=>
    dataMatch_r[0])
    else $error("longword equal to pattern did not match");

  chk_byte_lane: assert property (
    (busValid && busSize == SIZE_BYTE && trigEnByte[2'h3 - busAddr] && mask_r[0] == 32'h0 &&
    busData[8 * (3 - busAddr) +: 8] == pattern_r[0][8 * (3 - busAddr) +: 8]) |=> dataMatch_r[0])
    else $error("byte on addressed lane did not match");

  chk_word_size: assert property (
    (busValid && busSize == SIZE_WORD && !(busAddr[1] ? trigEnWordLower : trigEnWordUpper))
    |=> dataMatch_r == 2'h0)
    else $error("match on disabled word condition");

  chk_port_read: assert property (
    (portRdEn && portRegNum == REG_PATTERN_B && !wrEn) |=> (portRdAck_r &&
    portRdData_r == pattern_r[1]))
    else $error("pattern read back wrong");

  chk_port_wins: assert property (
    (portWrEn && instrWrEn && portRegNum == REG_PATTERN_A && instrRegNum == REG_PATTERN_A)
    |=> pattern_r[0] == $past(portWrData))
    else $error("instruction write beat port write");

  chk_mask_hidden: assert property (
    (portRdEn && (portRegNum == REG_MASK_A || portRegNum == REG_MASK_B)) |=>
    (portRdAck_r && portRdData_r == RD_NONE))
    else $error("mask register visible on port read");

endmodule

//--- verif/dbm_core_model.sv
// Purpose: core side model, asks to issue and completes every granted instruction
// Assumes: one completion per grant, issue request is a level
// Notes: slow stretches completion to four cycles; change it only while idle
`timescale 1ns/1ps
module dbm_core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic slow,
  input wire logic issueGrant_r,
  output logic issueReq,
  output logic instrDone
);
  // ********
  // completion pipe
  // ********
  logic [3:0] doneSh_r;
  assign issueReq = run;
  assign instrDone = slow ? doneSh_r[3] : doneSh_r[0];
  always_ff @(posedge clk) begin
    if (srst) begin
      doneSh_r <= 4'h0;
    end else begin
      doneSh_r <= {doneSh_r[2:0], issueGrant_r};
    end
  end
endmodule

//--- verif/dbm_data_match_test.sv
// Purpose: self-checking bench for the data match and execution control block
// Assumes: bench inputs move 2 ns after the rising edge, so nothing races the design
// Notes: patterns start unknown, so no match is tried before they are written
`timescale 1ns/1ps
module dbm_data_match_test;
  import dbm_pkg::*;
  // ********
  // signals
  // ********
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic instrWrEn = 1'h0, portWrEn = 1'h0, portRdEn = 1'h0, busValid = 1'h0;
  logic [4:0] instrRegNum = 5'h00, portRegNum = 5'h00;
  logic [31:0] instrWrData = 32'h0, portWrData = 32'h0, busData = 32'h0, portRdData_r;
  logic [1:0] busAddr = 2'h0, busSize = 2'h3, dataMatch_r;
  logic trigEnLong = 1'h1, trigEnWordUpper = 1'h1, trigEnWordLower = 1'h1;
  logic [3:0] trigEnByte = 4'hF;
  logic serialExecSelect = 1'h0, stepHaltEnable = 1'h0, pcBpHit = 1'h0, resumeCmd = 1'h0;
  logic run = 1'h0, slow = 1'h0;
  logic issueReq, instrDone, portRdAck_r, issueGrant_r, foldDisable_r, pcTrigReport_r, halted_r;
  int bad_count = 0, checks = 0, grants = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (issueGrant_r === 1'h1) grants++;
  dbm_data_match dbm_data_match_i (.clk, .srst, .instrWrEn, .instrRegNum, .instrWrData,
    .portWrEn, .portRdEn, .portRegNum, .portWrData, .portRdAck_r, .portRdData_r, .busValid,
    .busAddr, .busSize, .busData, .trigEnLong, .trigEnWordUpper, .trigEnWordLower, .trigEnByte,
    .dataMatch_r, .serialExecSelect, .stepHaltEnable, .issueReq, .instrDone, .pcBpHit,
    .resumeCmd, .issueGrant_r, .foldDisable_r, .pcTrigReport_r, .halted_r);
  dbm_core_model dbm_core_model_i (.clk, .srst, .run, .slow, .issueGrant_r, .issueReq,
    .instrDone);
  // ********
  // shared tasks
  // ********
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(logic viaPort, logic [4:0] num, logic [31:0] d);
    {portWrEn, instrWrEn} = {viaPort, !viaPort};
    {portRegNum, instrRegNum, portWrData, instrWrData} = {num, num, d, d};
    tick();
    {portWrEn, instrWrEn} = 2'h0;
    tick();
  endtask
  task automatic rd(logic [4:0] num, logic [31:0] exp);
    {portRdEn, portRegNum} = {1'h1, num};
    tick();
    portRdEn = 1'h0;
    cmp({portRdAck_r, portRdData_r}, {1'h1, exp});
    tick();
  endtask
  task automatic bus(logic [1:0] a, logic [1:0] s, logic [31:0] d, logic [1:0] exp);
    {busValid, busAddr, busSize, busData} = {1'h1, a, s, d};
    tick();
    busValid = 1'h0;
    cmp(dataMatch_r, exp);
    tick();
  endtask
  // waits for grant (0), completion (1) or halt (2), bounded
  task automatic waitOn(int sel, output int n);
    logic [2:0] v;
    n = 0;
    do begin
      tick();
      n++;
      v = {halted_r, instrDone, issueGrant_r};
    end while (n < 40 && v[sel] !== 1'h1);
  endtask
  // ********
  // scenarios
  // ********
  task automatic test_regs();
    wr(1'h0, REG_PATTERN_A, 32'h1234_5678);
    rd(REG_PATTERN_A, 32'h1234_5678);
    {portWrEn, instrWrEn, portRegNum, instrRegNum} = {2'h3, REG_PATTERN_A, REG_PATTERN_A};
    {portWrData, instrWrData} = {32'h1234_5678, 32'h5555_AAAA};
    tick();
    {portWrEn, instrWrEn} = 2'h0;
    tick();
    rd(REG_PATTERN_A, 32'h1234_5678);
    wr(1'h1, REG_PATTERN_B, 32'hA5A5_0F0F);
    wr(1'h1, 5'h0D, 32'hFFFF_FFFF);
    rd(REG_PATTERN_B, 32'hA5A5_0F0F);
    rd(5'h0D, RD_NONE);
    wr(1'h1, REG_MASK_A, 32'h0);
    wr(1'h0, REG_MASK_B, 32'h0000_00FF);
    rd(REG_MASK_A, RD_NONE);
  endtask
  task automatic test_match();
    bus(2'h0, SIZE_LONG, 32'h1234_5678, 2'h1);
    bus(2'h0, SIZE_LONG, 32'hA5A5_0F3C, 2'h2);
    bus(2'h0, SIZE_BYTE, 32'h12FF_FFFF, 2'h1);
    bus(2'h1, SIZE_BYTE, 32'hFF34_FFFF, 2'h1);
    bus(2'h2, SIZE_BYTE, 32'hFFFF_56FF, 2'h1);
    bus(2'h3, SIZE_BYTE, 32'h0000_0011, 2'h2);
    bus(2'h0, SIZE_WORD, 32'h1234_0000, 2'h1);
    bus(2'h1, SIZE_WORD, 32'hA5A5_1234, 2'h2);
    bus(2'h2, SIZE_WORD, 32'h0000_0F99, 2'h2);
    bus(2'h0, 2'h3, 32'h1234_5678, 2'h0);
    {trigEnLong, trigEnByte} = {1'h0, 4'h7};
    bus(2'h0, SIZE_LONG, 32'h1234_5678, 2'h0);
    bus(2'h0, SIZE_BYTE, 32'h12FF_FFFF, 2'h0);
    {trigEnLong, trigEnByte, trigEnWordUpper} = {1'h1, 4'hF, 1'h0};
    bus(2'h1, SIZE_WORD, 32'h1234_5678, 2'h0);
    bus(2'h2, SIZE_WORD, 32'hFFFF_5678, 2'h1);
    {trigEnWordUpper, trigEnWordLower} = 2'h2;
    bus(2'h2, SIZE_WORD, 32'hFFFF_5678, 2'h0);
    trigEnWordLower = 1'h1;
    wr(1'h1, REG_MASK_B, 32'hFFFF_FFFF);
    bus(2'h0, SIZE_LONG, 32'h0000_0000, 2'h2);
  endtask
  task automatic test_pipe();
    run = 1'h1;
    tick();
    cmp({issueGrant_r, foldDisable_r}, 2'h2);
    tick();
    cmp(issueGrant_r, 1'h1);
    pcBpHit = 1'h1;
    tick();
    cmp({pcTrigReport_r, issueGrant_r}, 2'h2);
    {pcBpHit, run} = 2'h0;
    tick(6);
  endtask
  task automatic test_serial();
    int n;
    {slow, serialExecSelect} = 2'h3;
    tick();
    cmp(foldDisable_r, 1'h1);
    run = 1'h1;
    waitOn(0, n);
    waitOn(1, n);
    waitOn(0, n);
    cmp(n, SERIAL_EXTRA_CYC + 2);
    {slow, serialExecSelect, run} = 3'h0;
    tick(12);
  endtask
  task automatic test_step();
    int n;
    int g0;
    {stepHaltEnable, run} = 2'h3;
    waitOn(2, n);
    g0 = grants;
    rd(REG_PATTERN_A, 32'h1234_5678);
    tick(3);
    cmp({halted_r, 8'(grants - g0)}, 9'h100);
    resumeCmd = 1'h1;
    tick();
    resumeCmd = 1'h0;
    cmp(halted_r, 1'h0);
    waitOn(2, n);
    tick(2);
    cmp({halted_r, 8'(grants - g0)}, 9'h101);
    {stepHaltEnable, resumeCmd} = 2'h1;
    tick();
    resumeCmd = 1'h0;
    tick(6);
    cmp({halted_r, issueGrant_r}, 2'h1);
    run = 1'h0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(5);
    srst = 1'h0;
    cmp({halted_r, issueGrant_r, portRdAck_r, dataMatch_r}, 5'h00);
    test_regs();
    test_match();
    test_pipe();
    test_serial();
    test_step();
    stop_test();
  end
  // the whole run needs under two hundred cycles; 4000 leaves ample slack
  initial begin
    #(25 * 4000);
    bad_count++;
    stop_test();
  end
endmodule
